/* File: logic/icu_params.svh */
// Purpose: register indices, field positions and reset values of the interrupt controller
// Assumes: included by the controller module and the testbench
// Notes:   byte address of a register is four times its index
`ifndef ICU_PARAMS_SVH
`define ICU_PARAMS_SVH

// ----------------------------------------
// register indices
// ----------------------------------------
`define ICU_IDX_EOSC 8'h22
`define ICU_IDX_POLL 8'h24
`define ICU_IDX_PSTAT 8'h26
`define ICU_IDX_MASK 8'h28
`define ICU_IDX_PRIMSK 8'h2A
`define ICU_IDX_INSERV 8'h2C
`define ICU_IDX_IREQ 8'h2E
`define ICU_IDX_ISTAT 8'h30
`define ICU_IDX_TCR 8'h32
`define ICU_IDX_EXT3 8'h3E

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define ICU_EOSC_NSPEC 15
`define ICU_POLL_PEND 15
`define ICU_CTL_RST 7'h0F
`define ICU_PRIMSK_RST 3'h7
`define ICU_WMASK_EXT01 7'h7F
`define ICU_WMASK_EXT23 7'h1F
`define ICU_WMASK_INTERNAL 7'h0F
`define ICU_IREQ_DMA_MASK 7'h06
`define ICU_SRC_EXT0 3
`define ICU_SRC_EXT1 4
`define ICU_SRC_EXT2 5
`define ICU_SRC_EXT3 6

`endif

/* File: logic/icu_pkg.sv */
// Purpose: shared types of the interrupt controller
// Assumes: nothing
// Notes:   control word layout matches the external input control word
package icu_pkg;
    localparam int ICU_NSRC = 7;

    // control word of one source
    typedef struct packed {
        logic nested_cascade_select;
        logic casc;
        logic level_trigger_select;
        logic msk;
        logic [2:0] prio;
    } icu_ctl_t;

    // vector answer towards the cpu
    typedef struct packed {
        logic valid;
        logic [7:0] vtype;
    } icu_vec_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_INT = 5'b00010,
        ST_ACK1 = 5'b00100,
        ST_GAP = 5'b01000,
        ST_ACK2 = 5'b10000
    } icu_st_t;
endpackage

/* File: logic/icu_prio_pick.sv */
// Purpose: pick the valid entry with the smallest key
// Assumes: keys are unique among valid entries
// Notes:   pure combinational
`timescale 1ns/100ps
`default_nettype none
module icu_prio_pick #(
    parameter int N = 7,
    parameter int KW = 6,
    parameter int IW = 3
) (
    input wire logic [N-1:0] valid,
    input wire logic [N*KW-1:0] keys,
    output logic any,
    output logic [IW-1:0] idx
);
    logic [KW-1:0] best;

    // linear scan, smaller key wins
    always_comb begin
        best = '1;
        any = 1'b0;
        idx = '0;
        for (int i = 0; i < N; i++) begin
            if (valid[i] && (!any || keys[i*KW +: KW] < best)) begin
                any = 1'b1;
                best = keys[i*KW +: KW];
                idx = IW'(i);
            end
        end
    end
endmodule // icu_prio_pick
`default_nettype wire

/* File: logic/icu_ext_sense.sv */
// Purpose: edge or level sensing of one external request pin
// Assumes: pin is synchronous to clock
// Notes:   arm flag starts clear so a pin high out of reset does not fire in edge mode
`timescale 1ns/100ps
`default_nettype none
module icu_ext_sense (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire logic pin,
    input wire logic level_mode,
    input wire logic ack,
    output logic req
);
    logic armed_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            armed_q <= 1'b0;
        end else if (ce) begin
            if (!pin) begin
                armed_q <= 1'b1;
            end else if (ack) begin
                armed_q <= 1'b0;
            end
        end
    end

    assign req = level_mode ? pin : (pin & armed_q);

    edge_hold_a: assert property (@(posedge clock) disable iff (rst)
        (ce && !level_mode && ack && pin) ##1 (ce && pin && !level_mode) |-> !req)
        else $error("edge input fired again without going low");
    level_follow_a: assert property (@(posedge clock) disable iff (rst)
        level_mode |-> (req == pin))
        else $error("level mode request does not follow pin");
endmodule // icu_ext_sense
`default_nettype wire

/* File: logic/icu_ctrl.sv */
// Purpose: master mode interrupt controller with apb register access
// Assumes: all inputs synchronous to clock; cpu raises inta_req for one cycle
// Notes:   sources 0 timer, 1 dma0, 2 dma1, 3..6 external inputs 0..3
//
// The APB interface to the registers and the placing of the registers were decided locally.
`include "icu_params.svh"
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - internal sources behave the same in every external pin mode
// - direct mode: four pins are requests, internal vectors, own in-service flag
// - a set in-service flag blocks lower priority sources
// - a set in-service flag blocks new requests from the same source
// - cascade pairs input 0 with ack pin 2, input 1 with ack pin 3
// - each pair selects cascade independently via its control word
// - nested cascade select accepts same pin while in service, still blocks lower
// - poll word bit 15 pending, bits 4..0 vector of best source
// - reading poll word sets in-service of best source
// - poll status word same content, no in-service change
// - 3-bit priority per source, lower number wins
// - equal levels resolved by fixed default order
// - nonspecific end-of-service clears best in-service flag
// - specific end-of-service clears only the named vector's flag
// - edge mode ignores high after ack until low one cycle
// - level mode requests while pin high
// - fixed vectors internally, external vectors for cascade or nested pins
// - cascaded source gets two ack cycles, vector read on second
// - level trigger select 1 level, 0 edge
// - end-of-service bit 15: 1 nonspecific, 0 specific
module icu_ctrl
    import icu_pkg::*;
#(
    parameter logic [34:0] VEC_TAB = {5'd15, 5'd14, 5'd13, 5'd12, 5'd11, 5'd10, 5'd8},
    parameter logic [20:0] TIE_RANK = {3'd6, 3'd5, 3'd4, 3'd3, 3'd2, 3'd1, 3'd0},
    parameter logic [7:0] VEC_NONE = 8'h00
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] timer_irq,
    input wire logic [1:0] dma_irq,
    input wire logic external_request_0,
    input wire logic external_request_1,
    input wire logic request2_or_ack0_in,
    output logic request2_or_ack0_out,
    output logic request2_or_ack0_oe_n,
    input wire logic request3_or_ack1_in,
    output logic request3_or_ack1_out,
    output logic request3_or_ack1_oe_n,
    input wire logic [7:0] ext_vector,
    input wire logic inta_req,
    output logic int_out,
    output icu_vec_t vec_out
);
    localparam int N = ICU_NSRC;

    icu_ctl_t ctl_q [N];
    logic [2:0] primask_q;
    logic [N-1:0] in_service_flag_q;
    logic [2:0] irt_q;
    logic [1:0] dreq_q;
    icu_st_t state_q;
    logic [2:0] ack_idx_q;
    logic ack_any_q;
    logic ack_pair_q;
    logic poll_any_q;
    logic [2:0] poll_idx_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic int_q;
    icu_vec_t vec_q;
    logic ack0_q, ack1_q, oe0_n_q, oe1_n_q;

    logic [N-1:0] req_v, elig_v, blk_v, set_v, clr_v;
    logic [N*6-1:0] key_v;
    logic [3:0] ext_req;
    logic [3:0] pin_v;
    logic [1:0] xmode;
    logic pend_any, isv_any;
    logic [2:0] pend_idx, isv_idx;
    logic [7:0] ridx;
    logic acc, acc_rd, acc_wr, setup, hit, ctl_sel;
    logic [2:0] ctl_src;
    logic [31:0] rd_d;
    logic ack_go, poll_go, xsrc;
    logic [2:0] irt_clr;

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    assign ridx = paddr[9:2];
    assign setup = psel && penable && !pready_q;
    assign acc = psel && penable && pready_q;
    assign acc_rd = acc && !pwrite;
    assign acc_wr = acc && pwrite;
    assign ctl_sel = (ridx >= `ICU_IDX_TCR) && (ridx <= `ICU_IDX_EXT3) && !ridx[0];
    assign ctl_src = 3'((ridx - `ICU_IDX_TCR) >> 1);

    // ----------------------------------------
    // request sources
    // ----------------------------------------
    // pin 2 and 3 become ack outputs when their pair is externally vectored
    // pair pin roles
    assign xmode[0] = ctl_q[`ICU_SRC_EXT0].casc | ctl_q[`ICU_SRC_EXT0].nested_cascade_select;
    assign xmode[1] = ctl_q[`ICU_SRC_EXT1].casc | ctl_q[`ICU_SRC_EXT1].nested_cascade_select;
    assign pin_v = {request3_or_ack1_in, request2_or_ack0_in, external_request_1, external_request_0};

    for (genvar k = 0; k < 4; k++) begin : g_ext
        icu_ext_sense u_sense (
            .clock(clock),
            .rst(rst),
            .ce(ce),
            .pin(pin_v[k]),
            .level_mode(ctl_q[`ICU_SRC_EXT0 + k].level_trigger_select),
            .ack(set_v[`ICU_SRC_EXT0 + k]),
            .req(ext_req[k])
        );
    end

    // internal sources independent of pin mode
    assign req_v = {ext_req[3] & !xmode[1], ext_req[2] & !xmode[0], ext_req[1:0], dreq_q, |irt_q};

    // tie order in key low bits
    always_comb begin
        for (int i = 0; i < N; i++) begin
            key_v[i*6 +: 6] = {ctl_q[i].prio, TIE_RANK[i*3 +: 3]};
        end
    end

    always_comb begin
        for (int i = 0; i < N; i++) begin
            blk_v[i] = in_service_flag_q[i] & !ctl_q[i].nested_cascade_select;
            for (int j = 0; j < N; j++) begin
                if (in_service_flag_q[j] && key_v[j*6 +: 6] < key_v[i*6 +: 6]) begin
                    blk_v[i] = 1'b1;
                end
            end
            elig_v[i] = req_v[i] && !ctl_q[i].msk && (ctl_q[i].prio <= primask_q) && !blk_v[i];
        end
    end

    icu_prio_pick #(.N(N), .KW(6), .IW(3)) u_pend (
        .valid(elig_v),
        .keys(key_v),
        .any(pend_any),
        .idx(pend_idx)
    );

    icu_prio_pick #(.N(N), .KW(6), .IW(3)) u_isv (
        .valid(in_service_flag_q),
        .keys(key_v),
        .any(isv_any),
        .idx(isv_idx)
    );

    // ----------------------------------------
    // grant and end-of-service
    // ----------------------------------------
    assign ack_go = (state_q == ST_IDLE) && inta_req;
    // poll read grants like an ack
    assign poll_go = acc_rd && (ridx == `ICU_IDX_POLL) && poll_any_q;
    assign xsrc = (pend_idx == 3'(`ICU_SRC_EXT0) && xmode[0]) || (pend_idx == 3'(`ICU_SRC_EXT1) && xmode[1]);
    assign irt_clr = irt_q & (~irt_q + 3'd1);

    always_comb begin
        set_v = '0;
        clr_v = '0;
        if (ack_go && pend_any) begin
            set_v[pend_idx] = 1'b1;
        end
        if (poll_go) begin
            set_v[poll_idx_q] = 1'b1;
        end
        if (acc_wr && ridx == `ICU_IDX_EOSC) begin
            if (pwdata[`ICU_EOSC_NSPEC]) begin
                if (isv_any) begin
                    clr_v[isv_idx] = 1'b1;
                end
            end else begin
                for (int i = 0; i < N; i++) begin
                    clr_v[i] = (VEC_TAB[i*5 +: 5] == pwdata[4:0]);
                end
            end
        end
    end

    // in-service flags, a set in the same cycle wins over a clear
    // one flag per source
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            in_service_flag_q <= '0;
        end else if (ce) begin
            if (acc_wr && ridx == `ICU_IDX_INSERV) begin
                in_service_flag_q <= pwdata[N-1:0] | set_v;
            end else begin
                in_service_flag_q <= (in_service_flag_q & ~clr_v) | set_v;
            end
        end
    end

    // internal request latches, arriving pulse beats the ack clear
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irt_q <= '0;
            dreq_q <= '0;
        end else if (ce) begin
            if (acc_wr && ridx == `ICU_IDX_ISTAT) begin
                irt_q <= pwdata[2:0] | timer_irq;
            end else begin
                irt_q <= (irt_q & ~(set_v[0] ? irt_clr : 3'b000)) | timer_irq;
            end
            if (acc_wr && ridx == `ICU_IDX_IREQ) begin
                dreq_q <= pwdata[2:1] | dma_irq;
            end else begin
                dreq_q <= (dreq_q & ~set_v[2:1]) | dma_irq;
            end
        end
    end

    // control words; mask register aliases the msk bits
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < N; i++) begin
                ctl_q[i] <= icu_ctl_t'(`ICU_CTL_RST);
            end
            primask_q <= `ICU_PRIMSK_RST;
        end else if (ce && acc_wr) begin
            if (ctl_sel) begin
                if (ctl_src == 3'(`ICU_SRC_EXT0) || ctl_src == 3'(`ICU_SRC_EXT1)) begin
                    ctl_q[ctl_src] <= icu_ctl_t'(pwdata[6:0] & `ICU_WMASK_EXT01);
                end else if (ctl_src >= 3'(`ICU_SRC_EXT2)) begin
                    ctl_q[ctl_src] <= icu_ctl_t'(pwdata[6:0] & `ICU_WMASK_EXT23);
                end else begin
                    ctl_q[ctl_src] <= icu_ctl_t'(pwdata[6:0] & `ICU_WMASK_INTERNAL);
                end
            end
            if (ridx == `ICU_IDX_MASK) begin
                for (int i = 0; i < N; i++) begin
                    ctl_q[i].msk <= pwdata[i];
                end
            end
            if (ridx == `ICU_IDX_PRIMSK) begin
                primask_q <= pwdata[2:0];
            end
        end
    end

    // ----------------------------------------
    // acknowledge sequence
    // ----------------------------------------
    // external vector only for cascade or nested pins
    // two ack cycles for cascaded source
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            ack_idx_q <= '0;
            ack_any_q <= 1'b0;
            ack_pair_q <= 1'b0;
        end else if (ce) begin
            unique case (state_q)
                ST_IDLE: begin
                    if (inta_req) begin
                        ack_idx_q <= pend_idx;
                        ack_any_q <= pend_any;
                        ack_pair_q <= (pend_idx == 3'(`ICU_SRC_EXT1));
                        state_q <= (pend_any && xsrc) ? ST_ACK1 : ST_INT;
                    end
                end
                ST_INT: state_q <= ST_IDLE;
                ST_ACK1: state_q <= ST_GAP;
                ST_GAP: state_q <= ST_ACK2;
                ST_ACK2: state_q <= ST_IDLE;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // cpu side outputs, vector answer one cycle after the last ack cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            vec_q <= '0;
            int_q <= 1'b0;
        end else if (ce) begin
            vec_q.valid <= (state_q == ST_INT) || (state_q == ST_ACK2);
            if (state_q == ST_ACK2) begin
                vec_q.vtype <= ext_vector;
            end else if (state_q == ST_INT) begin
                vec_q.vtype <= ack_any_q ? {3'b000, VEC_TAB[ack_idx_q*5 +: 5]} : VEC_NONE;
            end
            int_q <= pend_any && (state_q == ST_IDLE) && !inta_req;
        end
    end

    // ack pins, active low, enabled (low) whenever the pair is externally vectored
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ack0_q <= 1'b1;
            ack1_q <= 1'b1;
            oe0_n_q <= 1'b1;
            oe1_n_q <= 1'b1;
        end else if (ce) begin
            ack0_q <= !(ack_go && pend_any && xsrc && pend_idx == 3'(`ICU_SRC_EXT0))
                && !(state_q == ST_GAP && !ack_pair_q);
            ack1_q <= !(ack_go && pend_any && xsrc && pend_idx == 3'(`ICU_SRC_EXT1))
                && !(state_q == ST_GAP && ack_pair_q);
            oe0_n_q <= !xmode[0];
            oe1_n_q <= !xmode[1];
        end
    end

    // ----------------------------------------
    // apb read and handshake
    // ----------------------------------------
    // poll word layout
    always_comb begin
        rd_d = '0;
        hit = 1'b1;
        if (ctl_sel) begin
            rd_d[6:0] = ctl_q[ctl_src];
        end else begin
            unique case (ridx)
                `ICU_IDX_EOSC: rd_d = '0;
                `ICU_IDX_POLL, `ICU_IDX_PSTAT: begin
                    rd_d[`ICU_POLL_PEND] = pend_any;
                    rd_d[4:0] = VEC_TAB[pend_idx*5 +: 5];
                end
                `ICU_IDX_MASK: begin
                    for (int i = 0; i < N; i++) begin
                        rd_d[i] = ctl_q[i].msk;
                    end
                end
                `ICU_IDX_PRIMSK: rd_d[2:0] = primask_q;
                `ICU_IDX_INSERV: rd_d[N-1:0] = in_service_flag_q;
                `ICU_IDX_IREQ: rd_d[N-1:0] = req_v;
                `ICU_IDX_ISTAT: rd_d[2:0] = irt_q;
                default: hit = 1'b0;
            endcase
        end
    end

    // one wait state; data and poll winner frozen together so the grant matches
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
            poll_any_q <= 1'b0;
            poll_idx_q <= '0;
        end else if (ce) begin
            pready_q <= setup;
            pslverr_q <= setup && !hit;
            if (setup) begin
                prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
                poll_any_q <= pend_any;
                poll_idx_q <= pend_idx;
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign int_out = int_q;
    assign vec_out = vec_q;
    assign request2_or_ack0_out = ack0_q;
    assign request3_or_ack1_out = ack1_q;
    assign request2_or_ack0_oe_n = oe0_n_q;
    assign request3_or_ack1_oe_n = oe1_n_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    poll_grant_a: assert property (@(posedge clock) disable iff (rst)
        (ce && poll_go) |=> in_service_flag_q[$past(poll_idx_q)])
        else $error("poll read did not set in-service flag");
    pstat_keep_a: assert property (@(posedge clock) disable iff (rst)
        (ce && acc_rd && ridx == `ICU_IDX_PSTAT && !ack_go) |=> $stable(in_service_flag_q))
        else $error("poll status read changed in-service flags");
    eos_spec_a: assert property (@(posedge clock) disable iff (rst)
        (ce && acc_wr && ridx == `ICU_IDX_EOSC && !pwdata[`ICU_EOSC_NSPEC])
        |=> ((($past(in_service_flag_q) & ~in_service_flag_q) & ~$past(clr_v)) == '0))
        else $error("specific end-of-service cleared another flag");
    eos_nspec_a: assert property (@(posedge clock) disable iff (rst)
        (ce && acc_wr && ridx == `ICU_IDX_EOSC && pwdata[`ICU_EOSC_NSPEC] && isv_any && !ack_go)
        |=> !in_service_flag_q[$past(isv_idx)])
        else $error("nonspecific end-of-service missed best flag");
    two_ack_a: assert property (@(posedge clock) disable iff (rst)
        (ce && state_q == ST_ACK1) ##1 ce ##1 ce |-> state_q == ST_ACK2 ##1 vec_q.valid)
        else $error("cascade acknowledge not two cycles");
    same_src_a: assert property (@(posedge clock) disable iff (rst)
        pend_any |-> !(in_service_flag_q[pend_idx] && !ctl_q[pend_idx].nested_cascade_select))
        else $error("in-service source raised again");
    prio_mask_a: assert property (@(posedge clock) disable iff (rst)
        pend_any |-> ctl_q[pend_idx].prio <= primask_q)
        else $error("request above priority mask accepted");
    pair_dir_a: assert property (@(posedge clock) disable iff (rst)
        $past(ce) |-> (request2_or_ack0_oe_n == !$past(xmode[0])))
        else $error("ack pin 2 direction wrong");
    int_pend_a: assert property (@(posedge clock) disable iff (rst)
        int_out |-> $past(pend_any))
        else $error("interrupt raised with nothing eligible");
endmodule // icu_ctrl
`default_nettype wire

/* File: sim/icu_ext_ctl.sv */
// Purpose: model of a cascaded external controller on pair 0
// Assumes: the device pulses ack low twice per acknowledge
// Notes:   vector bus shows a changing pattern outside the second ack
`timescale 1ns/100ps
`default_nettype none
module icu_ext_ctl #(
    parameter logic [7:0] VEC = 8'h5A
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic ack_n,
    input wire logic raise,
    output logic req,
    output logic [7:0] vector
);
    logic ack_q;
    logic odd_q;
    logic [7:0] junk_q;
    // request and ack tracking; parity of ack falls marks the second ack
    // request held until ack
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ack_q <= 1'b1;
            odd_q <= 1'b0;
            req <= 1'b0;
            junk_q <= 8'h00;
        end else begin
            ack_q <= ack_n;
            junk_q <= ~junk_q;
            if (ack_q && !ack_n) begin
                odd_q <= ~odd_q;
            end
            if (raise) begin
                req <= 1'b1;
            end else if (ack_q && !ack_n) begin
                req <= 1'b0;
            end
        end
    end
    // vector on second ack only
    // junk elsewhere so a stale value cannot pass for an answer
    assign vector = (!ack_n && odd_q) ? VEC : junk_q;
endmodule // icu_ext_ctl
`default_nettype wire

/* File: sim/icu_ctrl_tb.sv */
// Purpose: self-checking bench of the interrupt controller
// Assumes: apb slave answers by pready, waits are bounded
// Notes:   pins 2 and 3 read low while released
`include "icu_params.svh"
`timescale 1ns/100ps
`default_nettype none
module icu_ctrl_tb import icu_pkg::*;;
    localparam logic [7:0] XVEC = 8'h5A;
    logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, inta_req = 0, e0 = 0, e1 = 0, raise = 0, er;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, q;
    int mismatches = 0, n_compared = 0;
    logic p2o, p2e, p3o, p3e, int_out, pready, pslverr, xreq;
    logic [31:0] prdata;
    logic [7:0] xv;
    icu_vec_t vec_out;
    // ordinary cases: ext0 ctl, ext1 ctl, pins, poll status
    logic [6:0] tc0 [3] = '{7'h13, 7'h12, 7'h11};
    logic [6:0] tc1 [3] = '{7'h12, 7'h12, 7'h15};
    logic [1:0] tpin [3] = '{2'b11, 2'b11, 2'b10};
    logic [31:0] tpst [3] = '{32'h0000_800D, 32'h0000_800C, 32'h0000_800D};
    icu_ctrl icu_ctrl_inst (.clock(clock), .rst(rst), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_irq(3'b000),
        .dma_irq(2'b00), .external_request_0(e0 | xreq), .external_request_1(e1),
        .request2_or_ack0_in(p2e ? 1'b0 : p2o), .request2_or_ack0_out(p2o), .request2_or_ack0_oe_n(p2e),
        .request3_or_ack1_in(p3e ? 1'b0 : p3o), .request3_or_ack1_out(p3o), .request3_or_ack1_oe_n(p3e),
        .ext_vector(xv), .inta_req(inta_req), .int_out(int_out), .vec_out(vec_out));
    icu_ext_ctl #(.VEC(XVEC)) icu_ext_ctl_inst (.clock(clock), .rst(rst), .ack_n(p2o), .raise(raise),
        .req(xreq), .vector(xv));
    initial begin
        forever #12.5 clock = ~clock;
    end
    task results;
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // one apb transfer; read data and error taken at the pready edge
    task apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= d;
        @(posedge clock);
        penable <= 1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        if (pready !== 1'b1) begin
            mismatches++;
            results();
        end
    endtask
    // inta pulse, then a bounded wait for the vector strobe
    task intack;
        inta_req <= 1;
        @(posedge clock);
        inta_req <= 0;
        for (int n = 0; n < 20 && vec_out.valid !== 1'b1; n++) @(negedge clock);
        if (vec_out.valid !== 1'b1) begin
            mismatches++;
            results();
        end
    endtask
    initial begin
        repeat (12) @(posedge clock);
        rst <= 0;
        @(negedge clock);
        cmp(32'({int_out, p2e, p3e, p2o}), 32'h0000_0007); // idle pins
        @(posedge clock);
        for (int i = 0; i < 3; i++) begin
            {e1, e0} <= tpin[i];
            apb(1, 8'h38, 32'(tc0[i]));
            apb(1, 8'h3A, 32'(tc1[i]));
            apb(0, `ICU_IDX_PSTAT, 0);
            cmp(q, tpst[i]);
        end
        $display("table done");
        {e1, e0} <= 2'b01;
        apb(0, `ICU_IDX_POLL, 0);
        cmp(q, 32'h0000_800C);
        e1 <= 1;
        apb(0, `ICU_IDX_PSTAT, 0);
        cmp(q & 32'h0000_8000, 0);
        apb(0, `ICU_IDX_INSERV, 0);
        cmp(q, 32'h0000_0008);
        apb(1, `ICU_IDX_EOSC, 32'h0000_8000);
        apb(0, `ICU_IDX_PSTAT, 0);
        cmp(q, 32'h0000_800C);
        e0 <= 0;
        apb(1, 8'h3A, 32'h0000_0005);
        apb(1, `ICU_IDX_EOSC, 32'h0000_8000);
        apb(0, `ICU_IDX_POLL, 0);
        cmp(q, 32'h0000_800D); // edge after arm
        apb(1, `ICU_IDX_EOSC, 32'h0000_000D);
        apb(0, `ICU_IDX_PSTAT, 0);
        cmp(q & 32'h0000_8000, 0); // high after ack
        e1 <= 0;
        @(posedge clock);
        e1 <= 1;
        apb(0, `ICU_IDX_PSTAT, 0);
        cmp(q, 32'h0000_800D); // rearm
        apb(0, `ICU_IDX_POLL, 0);
        apb(1, `ICU_IDX_EOSC, 32'h0000_000D);
        e1 <= 0;
        $display("poll and edge done");
        apb(1, 8'h38, 32'h0000_0020);
        raise <= 1;
        @(posedge clock);
        raise <= 0;
        repeat (3) @(posedge clock);
        cmp(32'({p2e, int_out}), 32'h0000_0001);
        intack();
        cmp(32'(vec_out), {23'h0, 1'b1, XVEC});
        apb(1, `ICU_IDX_EOSC, 32'h0000_000C);
        apb(0, `ICU_IDX_INSERV, 0);
        cmp(q, 0);
        $display("cascade done");
        // internal source while pair 0 cascades
        apb(1, 8'h34, 32'h0000_0001);
        apb(1, `ICU_IDX_IREQ, 32'h0000_0002);
        intack();
        cmp(32'(vec_out), 32'h0000_010A);
        apb(0, `ICU_IDX_INSERV, 0);
        cmp(q, 32'h0000_0002);
        apb(1, `ICU_IDX_EOSC, 32'h0000_8000);
        // nested cascade on pair 1: own flag must not block the pin
        apb(1, 8'h3A, 32'h0000_0040);
        e1 <= 1;
        apb(0, `ICU_IDX_POLL, 0);
        cmp(q, 32'h0000_800D);
        e1 <= 0;
        @(posedge clock);
        e1 <= 1;
        apb(0, `ICU_IDX_PSTAT, 0);
        cmp(q, 32'h0000_800D);
        cmp(32'({p3e, p3o}), 32'h0000_0001);
        apb(1, `ICU_IDX_EOSC, 32'h0000_000D);
        e1 <= 0;
        $display("nested cascade done");
        rst <= 1;
        repeat (2) @(posedge clock);
        rst <= 0;
        @(negedge clock);
        cmp(32'({int_out, p2e, p3e, p2o, p3o}), 32'h0000_000F);
        @(posedge clock);
        apb(0, 8'h3A, 0);
        cmp(q, 32'h0000_000F);
        apb(0, 8'h10, 0);
        cmp(32'(er), 32'h0000_0001);
        $display("reset and error done");
        results();
    end
endmodule // icu_ctrl_tb
`default_nettype wire
